// ### core/ssel_pkg.sv
// Constants shared by the second-function source select block.
package ssel_pkg;
    localparam logic [7:0] SSEL_LATCH_A_ADDR = 8'h46;
    localparam logic [7:0] SSEL_LATCH_B_ADDR = 8'h47;
    // Destination registers used when a parameter is register sourced.
    localparam logic [7:0] SSEL_FREQ_CFG_ADDR = 8'h30;
    localparam logic [7:0] SSEL_LL_CFG_ADDR = 8'h39;
    localparam logic [7:0] SSEL_OCP_CFG_ADDR = 8'h2E;
    localparam logic [7:0] SSEL_THR1_CFG_ADDR = 8'h3A;
    localparam logic [7:0] SSEL_THR4_CFG_ADDR = 8'h40;
    localparam int SSEL_FREQ_BIT = 5;
    localparam int SSEL_LL_BIT = 4;
    localparam int SSEL_OCP_BIT = 2;
    localparam int SSEL_THR_BIT = 0;
    localparam logic [7:0] SSEL_SEL_MASK = 8'h35;
    localparam logic [7:0] SSEL_SEL_RESET = 8'h00;
    localparam logic [7:0] SSEL_THR_OFF_CODE = 8'hFF;
    localparam logic [7:0] SSEL_ZERO_BYTE = 8'h00;
    localparam int SSEL_NUM_THR = 4;
endpackage

// ### core/ssel_thr_if.sv
// Carrier between the select core and the threshold selector.
`timescale 1ns/1ps
interface ssel_thr_if;
    import ssel_pkg::*;
    logic sel;
    logic [SSEL_NUM_THR-1:0][7:0] cfg;
    logic [SSEL_NUM_THR-1:0][7:0] strap;
    logic [SSEL_NUM_THR-1:0] strap_off;
    logic [SSEL_NUM_THR-1:0][7:0] thr;
    logic [SSEL_NUM_THR-1:0] thr_en;
    modport core (output sel, output cfg, output strap, output strap_off,
                  input thr, input thr_en);
    modport sel_side (input sel, input cfg, input strap, input strap_off,
                      output thr, output thr_en);
endinterface

// ### core/ssel_thresh.sv
// Per-threshold source selection and disable logic.
`timescale 1ns/1ps
module ssel_thresh (
    input wire logic mclk, // System clock.
    input wire logic rst_n, // Asynchronous reset, active low.
    ssel_thr_if.sel_side tif // Threshold selection carrier.
);
    import ssel_pkg::*;

    typedef struct packed {
        logic [SSEL_NUM_THR-1:0][7:0] thr;
        logic [SSEL_NUM_THR-1:0] en;
    } ssel_thr_state_type;

    ssel_thr_state_type st_reg;
    ssel_thr_state_type st_next;
    logic [SSEL_NUM_THR-1:0][7:0] val_w;
    logic [SSEL_NUM_THR-1:0] en_w;

    genvar gi;
    generate
        for (gi = 0; gi < SSEL_NUM_THR; gi++)
        begin : g_thr
            assign val_w[gi] = tif.sel ? tif.cfg[gi] : tif.strap[gi]; // [R04]
            // An all-ones code switches the threshold off in register mode.
            assign en_w[gi] = tif.sel ? (tif.cfg[gi] != SSEL_THR_OFF_CODE)
                                      : !tif.strap_off[gi]; // [R08]
        end
    endgenerate

    always_comb
    begin
        st_next = st_reg;
        st_next.thr = val_w;
        st_next.en = en_w;
    end

    always_ff @(posedge mclk or negedge rst_n)
    begin
        if (!rst_n)
        begin
            st_reg <= '0;
        end
        else
        begin
            st_reg <= st_next;
        end
    end

    assign tif.thr = st_reg.thr;
    assign tif.thr_en = st_reg.en;

    thr_off_a: assert property (@(posedge mclk) disable iff (!rst_n) // [R08]
        (tif.sel && tif.cfg[0] == SSEL_THR_OFF_CODE) |=> !tif.thr_en[0])
        else $error("Threshold 0 not disabled by all-ones code.");
    thr_src_a: assert property (@(posedge mclk) disable iff (!rst_n) // [R04]
        !tif.sel |=> tif.thr[SSEL_NUM_THR-1] == $past(tif.strap[SSEL_NUM_THR-1]))
        else $error("Threshold not taken from strap in strap mode.");
endmodule

// ### core/ssel_top.sv
// Second-function source select latch pair with threshold selection.
`timescale 1ns/1ps
// Summary of operation
// R01 - Latch bit 5 picks switching frequency from strap (0) or register 0x30 (1).
// R02 - Latch bit 4 picks load line from strap (0) or register 0x39 (1).
// R03 - Latch bit 2 picks overcurrent limit from strap (0) or register 0x2E (1).
// R04 - Latch bit 0 picks all four shedding thresholds from straps or registers.
// R05 - Bits 7:6, 3 and 1 of both latches are ignored and read zero.
// R06 - New selection applies only when both latches hold the same byte.
// R07 - Any enable toggle returns every parameter to strap control.
// R08 - In register threshold mode an all-ones threshold is disabled.
module ssel_top (
    input wire logic mclk, // System clock, 100 MHz.
    input wire logic rst_n, // Asynchronous reset, active low.
    input wire logic en, // Controller enable pin level.
    input wire logic [7:0] reg_addr, // Register address from the serial port.
    input wire logic [7:0] reg_wdata, // Write data.
    input wire logic reg_wr, // Write strobe, one cycle.
    input wire logic reg_rd, // Read strobe, one cycle.
    output logic [7:0] reg_rdata, // Read data, valid the cycle after reg_rd.
    output logic switching_freq_source, // 1 = register sourced frequency.
    output logic load_line_source, // 1 = register sourced load line.
    output logic overcurrent_limit_source, // 1 = register sourced limit.
    output logic shed_threshold_source, // 1 = register sourced thresholds.
    input wire logic [ssel_pkg::SSEL_NUM_THR-1:0][7:0] thr_cfg, // Threshold config regs.
    input wire logic [ssel_pkg::SSEL_NUM_THR-1:0][7:0] thr_strap, // Strap thresholds.
    input wire logic [ssel_pkg::SSEL_NUM_THR-1:0] thr_strap_off, // Strap says disabled.
    output logic [ssel_pkg::SSEL_NUM_THR-1:0][7:0] thr_value, // Selected thresholds.
    output logic [ssel_pkg::SSEL_NUM_THR-1:0] thr_enable // Threshold in use.
);
    import ssel_pkg::*;

    typedef struct packed {
        logic en_q;
        logic [7:0] latch_a;
        logic [7:0] latch_b;
        logic [7:0] eff;
        logic [7:0] rdata;
    } ssel_state_type;

    ssel_state_type st_reg;
    ssel_state_type st_next;
    logic toggle;
    ssel_thr_if tif ();

    assign toggle = en != st_reg.en_q;

    always_comb
    begin
        st_next = st_reg;
        st_next.en_q = en;
        st_next.rdata = SSEL_ZERO_BYTE;
        if (reg_wr && reg_addr == SSEL_LATCH_A_ADDR)
        begin
            st_next.latch_a = reg_wdata & SSEL_SEL_MASK; // [R05]
        end
        if (reg_wr && reg_addr == SSEL_LATCH_B_ADDR)
        begin
            st_next.latch_b = reg_wdata & SSEL_SEL_MASK; // [R05]
        end
        if (reg_rd && reg_addr == SSEL_LATCH_A_ADDR)
        begin
            st_next.rdata = st_reg.latch_a;
        end
        if (reg_rd && reg_addr == SSEL_LATCH_B_ADDR)
        begin
            st_next.rdata = st_reg.latch_b;
        end
        // The enable toggle outranks a same-cycle latch write, so a stale
        // register selection can never survive a power cycle of the rail.
        if (toggle)
        begin
            st_next.latch_a = SSEL_SEL_RESET; // [R07]
            st_next.latch_b = SSEL_SEL_RESET;
            st_next.eff = SSEL_SEL_RESET;
        end
        else if (st_reg.latch_a == st_reg.latch_b)
        begin
            st_next.eff = st_reg.latch_a; // [R06]
        end
    end

    always_ff @(posedge mclk or negedge rst_n)
    begin
        if (!rst_n)
        begin
            st_reg <= '0;
        end
        else
        begin
            st_reg <= st_next;
        end
    end

    assign reg_rdata = st_reg.rdata;
    assign switching_freq_source = st_reg.eff[SSEL_FREQ_BIT]; // [R01]
    assign load_line_source = st_reg.eff[SSEL_LL_BIT]; // [R02]
    assign overcurrent_limit_source = st_reg.eff[SSEL_OCP_BIT]; // [R03]
    assign shed_threshold_source = st_reg.eff[SSEL_THR_BIT]; // [R04]

    assign tif.sel = st_reg.eff[SSEL_THR_BIT]; // [R04]
    assign tif.cfg = thr_cfg;
    assign tif.strap = thr_strap;
    assign tif.strap_off = thr_strap_off;
    assign thr_value = tif.thr;
    assign thr_enable = tif.thr_en;

    ssel_thresh u_thresh (
        .mclk(mclk),
        .rst_n(rst_n),
        .tif(tif)
    );

    sequence s_match;
        !toggle && st_reg.latch_a == st_reg.latch_b;
    endsequence

    sequence s_mismatch;
        !toggle && st_reg.latch_a != st_reg.latch_b;
    endsequence

    freq_track_a: assert property (@(posedge mclk) disable iff (!rst_n) // [R01]
        s_match |=> switching_freq_source == $past(st_reg.latch_a[SSEL_FREQ_BIT]))
        else $error("Frequency source does not follow matched latches.");
    ll_track_a: assert property (@(posedge mclk) disable iff (!rst_n) // [R02]
        s_match |=> load_line_source == $past(st_reg.latch_a[SSEL_LL_BIT]))
        else $error("Load line source does not follow matched latches.");
    ocp_track_a: assert property (@(posedge mclk) disable iff (!rst_n) // [R03]
        s_match |=> overcurrent_limit_source == $past(st_reg.latch_b[SSEL_OCP_BIT]))
        else $error("Overcurrent source does not follow matched latches.");
    shed_track_a: assert property (@(posedge mclk) disable iff (!rst_n) // [R04]
        s_match |=> shed_threshold_source == $past(st_reg.latch_b[SSEL_THR_BIT]))
        else $error("Threshold source does not follow matched latches.");
    rsvd_read_a: assert property (@(posedge mclk) disable iff (!rst_n) // [R05]
        reg_rd |=> (reg_rdata & ~SSEL_SEL_MASK) == SSEL_ZERO_BYTE)
        else $error("Reserved latch bits read nonzero.");
    mismatch_hold_a: assert property (@(posedge mclk) disable iff (!rst_n) // [R06]
        s_mismatch |=> $stable(st_reg.eff))
        else $error("Selection changed while latches differ.");
    en_toggle_a: assert property (@(posedge mclk) disable iff (!rst_n) // [R07]
        toggle |=> (st_reg.eff == SSEL_SEL_RESET) ##1 !switching_freq_source)
        else $error("Enable toggle did not restore strap control.");

    sequence s_wr_a;
        reg_wr && reg_addr == SSEL_LATCH_A_ADDR && !toggle;
    endsequence

    sequence s_wr_b;
        reg_wr && reg_addr == SSEL_LATCH_B_ADDR && !toggle;
    endsequence

    sequence s_rd_a;
        reg_rd && reg_addr == SSEL_LATCH_A_ADDR;
    endsequence

    sequence s_rd_b;
        reg_rd && reg_addr == SSEL_LATCH_B_ADDR;
    endsequence

    sequence s_strap_ctl;
        !switching_freq_source && !load_line_source && !overcurrent_limit_source
            && !shed_threshold_source;
    endsequence

    // The host port leaves one idle cycle between two writes, so these pairs are
    // matched two cycles apart; back-to-back pairs are left to sel_apply_a.
    sequence s_pair_ab;
        s_wr_a ##1 (!reg_wr && !toggle)
            ##1 (reg_wr && reg_addr == SSEL_LATCH_B_ADDR && !toggle
            && reg_wdata == $past(reg_wdata, 2));
    endsequence

    sequence s_pair_ba;
        s_wr_b ##1 (!reg_wr && !toggle)
            ##1 (reg_wr && reg_addr == SSEL_LATCH_A_ADDR && !toggle
            && reg_wdata == $past(reg_wdata, 2));
    endsequence

    // Only selection bits are ever stored, so reserved bits can never steer a source.
    write_a_mask_a: assert property (@(posedge mclk) disable iff (!rst_n) // [R05]
        s_wr_a |=> st_reg.latch_a == ($past(reg_wdata) & SSEL_SEL_MASK))
        else $error("Latch A did not store the masked write byte.");
    write_b_mask_a: assert property (@(posedge mclk) disable iff (!rst_n) // [R05]
        s_wr_b |=> st_reg.latch_b == ($past(reg_wdata) & SSEL_SEL_MASK))
        else $error("Latch B did not store the masked write byte.");
    rsvd_store_a: assert property (@(posedge mclk) disable iff (!rst_n) // [R05]
        ((st_reg.latch_a | st_reg.latch_b | st_reg.eff) & ~SSEL_SEL_MASK) == SSEL_ZERO_BYTE)
        else $error("Reserved bit held in a latch or in the selection.");

    // Read data stands for one cycle only, so a host that samples late sees zero
    // rather than a stale latch value that could be taken for a fresh one.
    read_a_data_a: assert property (@(posedge mclk) disable iff (!rst_n) // [R05]
        s_rd_a |=> reg_rdata == $past(st_reg.latch_a))
        else $error("Latch A read returned the wrong byte.");
    read_b_data_a: assert property (@(posedge mclk) disable iff (!rst_n) // [R05]
        s_rd_b |=> reg_rdata == $past(st_reg.latch_b))
        else $error("Latch B read returned the wrong byte.");
    read_unmapped_a: assert property (@(posedge mclk) disable iff (!rst_n) // [R05]
        (reg_rd && reg_addr != SSEL_LATCH_A_ADDR && reg_addr != SSEL_LATCH_B_ADDR)
            |=> reg_rdata == SSEL_ZERO_BYTE)
        else $error("Read of an unmapped address returned nonzero.");
    rdata_idle_a: assert property (@(posedge mclk) disable iff (!rst_n) // [R05]
        !reg_rd |=> reg_rdata == SSEL_ZERO_BYTE)
        else $error("Read data not zero outside a read.");

    // The selection may move only on a matched pair or an enable toggle.
    sel_apply_a: assert property (@(posedge mclk) disable iff (!rst_n) // [R06]
        s_match |=> st_reg.eff == $past(st_reg.latch_a))
        else $error("Matched latches not applied as the selection.");
    latch_hold_a: assert property (@(posedge mclk) disable iff (!rst_n) // [R06]
        (!reg_wr && !toggle) |=> $stable(st_reg.latch_a) && $stable(st_reg.latch_b))
        else $error("Latch changed without a write or a toggle.");
    pair_ab_a: assert property (@(posedge mclk) disable iff (!rst_n) // [R06]
        s_pair_ab |=> (!toggle |=> st_reg.eff == ($past(reg_wdata, 2) & SSEL_SEL_MASK)))
        else $error("Matched pair written A then B was not applied.");
    pair_ba_a: assert property (@(posedge mclk) disable iff (!rst_n) // [R06]
        s_pair_ba |=> (!toggle |=> st_reg.eff == ($past(reg_wdata, 2) & SSEL_SEL_MASK)))
        else $error("Matched pair written B then A was not applied.");

    // Both enable edges count, so the history must follow the pin every cycle.
    en_history_a: assert property (@(posedge mclk) disable iff (!rst_n) // [R07]
        $past(rst_n) |-> st_reg.en_q == $past(en))
        else $error("Enable history does not follow the pin.");
    toggle_clear_a: assert property (@(posedge mclk) disable iff (!rst_n) // [R07]
        toggle |=> st_reg.latch_a == SSEL_SEL_RESET && st_reg.latch_b == SSEL_SEL_RESET)
        else $error("Enable toggle did not clear both latches.");
    strap_hold_a: assert property (@(posedge mclk) disable iff (!rst_n) // [R07]
        toggle |=> s_strap_ctl ##1 s_strap_ctl)
        else $error("Strap control not held after an enable toggle.");
endmodule

// ### tb/ssel_host_model.sv
// Host model that drives the serial configuration register port.
`timescale 1ns/1ps
module ssel_host_model (
    input wire logic mclk, // Clock.
    output logic [7:0] reg_addr, // Address.
    output logic [7:0] reg_wdata, // Write data.
    output logic reg_wr, // Write strobe.
    output logic reg_rd, // Read strobe.
    input wire logic [7:0] reg_rdata // Read data.
);
    initial
    begin
        reg_addr = 8'h00;
        reg_wdata = 8'h00;
        reg_wr = 1'b0;
        reg_rd = 1'b0;
    end
    // One write or read; a selection change is two writes of one byte.
    task automatic xfer(input logic w, input logic [7:0] a, input logic [7:0] d,
                        output logic [7:0] q);
        @(posedge mclk);
        #1;
        reg_addr = a;
        reg_wdata = d;
        reg_wr = w;
        reg_rd = !w;
        @(posedge mclk);
        #1;
        reg_wr = 1'b0;
        reg_rd = 1'b0;
        // Released data is inverted so a stale value is never mistaken for valid.
        reg_wdata = ~d;
        q = reg_rdata;
    endtask
endmodule

// ### tb/tb.sv
// Self-checking bench for the source select latch pair.
`timescale 1ns/1ps
`define CHK(a, b) begin checks++; if ((a) !== (b)) begin failures++; \
    $display("mismatch at %0t: %h %h", $time, a, b); end end
module tb;
    import ssel_pkg::*;
    int failures = 0;
    int checks = 0;
    logic mclk;
    logic rst_n;
    logic en;
    logic f;
    logic [7:0] reg_addr, reg_wdata, reg_rdata, d, r, sel;
    logic reg_wr, reg_rd;
    logic [3:0] src, off, tena;
    logic [3:0][7:0] cfg, strap, tval;
    ssel_host_model ssel_host_model_inst (.mclk(mclk), .reg_addr(reg_addr),
        .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata));
    ssel_top ssel_top_inst (.mclk(mclk), .rst_n(rst_n), .en(en), .reg_addr(reg_addr),
        .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata),
        .switching_freq_source(src[3]), .load_line_source(src[2]),
        .overcurrent_limit_source(src[1]), .shed_threshold_source(src[0]),
        .thr_cfg(cfg), .thr_strap(strap), .thr_strap_off(off), .thr_value(tval),
        .thr_enable(tena));
    function automatic logic [35:0] exp_thr(input logic s);
        logic [35:0] v;
        for (int i = 0; i < SSEL_NUM_THR; i++)
        begin
            v[8*i+:8] = s ? cfg[i] : strap[i];
            v[32+i] = s ? (cfg[i] !== SSEL_THR_OFF_CODE) : !off[i];
        end
        return v;
    endfunction
    task automatic wr(input logic [7:0] a, input logic [7:0] v);
        ssel_host_model_inst.xfer(1'b1, a, v, r);
    endtask
    task automatic rd(input logic [7:0] a);
        ssel_host_model_inst.xfer(1'b0, a, 8'h00, r);
    endtask
    task automatic results();
        if (failures == 0 && checks > 0)
            $display("RESULT: PASS");
        else
            $display("RESULT: FAIL");
        $finish;
    endtask
    initial
    begin
        mclk = 1'b0;
        forever #5 mclk = ~mclk;
    end
    initial
    begin
        #300000;
        failures++;
        results();
    end
    initial
    begin
        rst_n = 1'b0;
        en = 1'b0;
        cfg = '0;
        strap = '0;
        off = 4'h0;
        sel = 8'h00;
        void'($urandom(92155));
        repeat (5) @(posedge mclk);
        #1;
        rst_n = 1'b1;
        repeat (2) @(posedge mclk);
        for (int n = 0; n < 24; n++)
        begin
            d = (n == 0) ? 8'hFF : 8'($urandom);
            f = 1'($urandom);
            wr(f ? SSEL_LATCH_B_ADDR : SSEL_LATCH_A_ADDR, d);
            `CHK(src, {sel[5], sel[4], sel[2], sel[0]})
            wr(f ? SSEL_LATCH_A_ADDR : SSEL_LATCH_B_ADDR, (n % 3 == 2) ? d ^ 8'h01 : d);
            if (n % 3 != 2)
                sel = d & SSEL_SEL_MASK;
            repeat (2) @(posedge mclk);
            #1;
            `CHK(src, {sel[5], sel[4], sel[2], sel[0]})
            rd(f ? SSEL_LATCH_B_ADDR : SSEL_LATCH_A_ADDR);
            `CHK(r, d & SSEL_SEL_MASK)
            cfg = {$urandom};
            if (n % 2 == 0)
                cfg[n % 4] = SSEL_THR_OFF_CODE;
            strap = {$urandom};
            off = 4'($urandom);
            @(posedge mclk);
            #1;
            `CHK({tena, tval}, exp_thr(sel[0]))
        end
        rd(SSEL_FREQ_CFG_ADDR);
        `CHK(r, 8'h00)
        for (int k = 0; k < 2; k++)
        begin
            wr(SSEL_LATCH_A_ADDR, 8'hFF);
            wr(SSEL_LATCH_B_ADDR, 8'hFF);
            @(posedge mclk);
            #1;
            `CHK(src, 4'hF)
            en = ~en;
            repeat (3) @(posedge mclk);
            #1;
            `CHK(src, 4'h0)
            rd(SSEL_LATCH_A_ADDR);
            `CHK(r, 8'h00)
        end
        results();
    end
endmodule
